// File: hw/crm_top.sv
// receive mask selection, identifier masks and buffer full/overflow flags
`timescale 1ns/10ps
`include "crm_regs.svh"
module crm_top #(
   parameter int N_MASK = 3,  // acceptance masks
   parameter int N_FLT = 4,   // filters 8 to 11
   parameter int N_BUF = 32,  // receive buffers
   parameter int BUF_W = 5    // buffer index width
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic msg_valid,
   input wire logic msg_ide,
   input wire logic [10:0] msg_sid,
   input wire logic [17:0] msg_eid,
   output logic rx_store_valid,
   output logic [BUF_W-1:0] rx_store_buf,
   output logic [3:0] rx_store_filter,
   output logic rx_store_overflow,
   output logic irq
);
   // merge write data into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] wm);
      merge = (old_v & ~wm) | (new_v & wm);
   endfunction

   // configuration resets to zero, so a fresh part accepts nothing
   // until software enables at least one filter
   // register state
   logic [15:0] msel_r;                 // filter mask select fields
   logic [15:0] mask_sid_r [N_MASK];    // standard id masks
   logic [15:0] mask_eid_r [N_MASK];    // extended id masks
   logic [15:0] flt_sid_r [N_FLT];      // filter standard values
   logic [15:0] flt_eid_r [N_FLT];      // filter extended values
   logic [N_FLT-1:0] flt_en_r;          // filter enables
   logic [N_FLT*BUF_W-1:0] flt_tgt_r;   // target buffer per filter
   logic [N_BUF-1:0] full_r;            // buffer full flags
   logic [N_BUF-1:0] ovf_r;             // buffer overflow flags
   logic [`CRM_EV_W-1:0] int_stat_r;    // sticky events
   logic [`CRM_EV_W-1:0] int_mask_r;    // event enables
   logic [31:0] prdata_r;               // captured read data
   logic err_r;                         // captured decode error

   // bus decode
   logic setup_w;       // setup phase
   logic wr_w;          // write takes effect this edge
   logic [31:0] wm_w;   // byte lane mask
   logic [31:0] rd_w;   // selected read word
   logic hit_any_w;     // address maps to a register

   // zero wait slave: access phase always completes at once
   assign pready = psel && penable;
   assign pslverr = pready && err_r;
   assign prdata = prdata_r;
   assign setup_w = psel && !penable;
   assign wr_w = psel && penable && pwrite;
   assign wm_w = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // single register hits
   logic hit_msel, hit_full_lo, hit_full_hi, hit_ovf_lo, hit_ovf_hi;
   logic hit_ist, hit_imsk, hit_fen, hit_ftgt;
   assign hit_msel = (paddr == `CRM_OFF_MSEL);
   assign hit_full_lo = (paddr == `CRM_OFF_FULL_LO);
   assign hit_full_hi = (paddr == `CRM_OFF_FULL_HI);
   assign hit_ovf_lo = (paddr == `CRM_OFF_OVF_LO);
   assign hit_ovf_hi = (paddr == `CRM_OFF_OVF_HI);
   assign hit_ist = (paddr == `CRM_OFF_INT_STAT);
   assign hit_imsk = (paddr == `CRM_OFF_INT_MASK);
   assign hit_fen = (paddr == `CRM_OFF_FLT_EN);
   assign hit_ftgt = (paddr == `CRM_OFF_FLT_TGT);

   // array register hits and their read terms
   logic [N_MASK-1:0] hit_msid, hit_meid;
   logic [N_FLT-1:0] hit_fsid, hit_feid;
   logic [31:0] rd_msid [N_MASK];
   logic [31:0] rd_meid [N_MASK];
   logic [31:0] rd_fsid [N_FLT];
   logic [31:0] rd_feid [N_FLT];
   logic [31:0] rd_arr [N_MASK+N_FLT+1];  // or-chain of array reads

   // mask register file
   for (genvar m = 0; m < N_MASK; m++) begin : g_mask
      assign hit_msid[m] = (paddr == 8'(`CRM_OFF_MSID0 + 4 * m));
      assign hit_meid[m] = (paddr == 8'(`CRM_OFF_MEID0 + 4 * m));
      assign rd_msid[m] = hit_msid[m] ? {16'h0000, mask_sid_r[m]} : `CRM_WORD_RST;
      assign rd_meid[m] = hit_meid[m] ? {16'h0000, mask_eid_r[m]} : `CRM_WORD_RST;
      // mask writes
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            mask_sid_r[m] <= `CRM_CFG_RST;
            mask_eid_r[m] <= `CRM_CFG_RST;
         end else if (wr_w) begin
            if (hit_msid[m]) begin
               mask_sid_r[m] <= 16'(merge({16'h0000, mask_sid_r[m]}, pwdata, wm_w))
                                & `CRM_SID_WMASK;
            end
            if (hit_meid[m]) begin
               mask_eid_r[m] <= 16'(merge({16'h0000, mask_eid_r[m]}, pwdata, wm_w));
            end
         end
      end
   end

   // filter value register file
   for (genvar f = 0; f < N_FLT; f++) begin : g_fval
      assign hit_fsid[f] = (paddr == 8'(`CRM_OFF_FSID0 + 4 * f));
      assign hit_feid[f] = (paddr == 8'(`CRM_OFF_FEID0 + 4 * f));
      assign rd_fsid[f] = hit_fsid[f] ? {16'h0000, flt_sid_r[f]} : `CRM_WORD_RST;
      assign rd_feid[f] = hit_feid[f] ? {16'h0000, flt_eid_r[f]} : `CRM_WORD_RST;
      // filter value writes, same unused bits as the masks
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            flt_sid_r[f] <= `CRM_CFG_RST;
            flt_eid_r[f] <= `CRM_CFG_RST;
         end else if (wr_w) begin
            if (hit_fsid[f]) begin
               flt_sid_r[f] <= 16'(merge({16'h0000, flt_sid_r[f]}, pwdata, wm_w))
                               & `CRM_SID_WMASK;
            end
            if (hit_feid[f]) begin
               flt_eid_r[f] <= 16'(merge({16'h0000, flt_eid_r[f]}, pwdata, wm_w));
            end
         end
      end
   end

   // fold all array reads into one word
   assign rd_arr[0] = `CRM_WORD_RST;
   for (genvar k = 0; k < N_MASK; k++) begin : g_rdm
      assign rd_arr[k+1] = rd_arr[k] | rd_msid[k] | rd_meid[k];
   end
   for (genvar k = 0; k < N_FLT; k++) begin : g_rdf
      assign rd_arr[N_MASK+k+1] = rd_arr[N_MASK+k] | rd_fsid[k] | rd_feid[k];
   end

   // read selection, narrow registers zero extended
   assign hit_any_w = hit_msel || hit_full_lo || hit_full_hi || hit_ovf_lo ||
                      hit_ovf_hi || hit_ist || hit_imsk || hit_fen || hit_ftgt ||
                      (|hit_msid) || (|hit_meid) || (|hit_fsid) || (|hit_feid);
   assign rd_w = rd_arr[N_MASK+N_FLT]
      | (hit_msel ? {16'h0000, msel_r} : `CRM_WORD_RST)
      | (hit_full_lo ? {16'h0000, full_r[15:0]} : `CRM_WORD_RST)
      | (hit_full_hi ? {16'h0000, full_r[31:16]} : `CRM_WORD_RST)
      | (hit_ovf_lo ? {16'h0000, ovf_r[15:0]} : `CRM_WORD_RST)
      | (hit_ovf_hi ? {16'h0000, ovf_r[31:16]} : `CRM_WORD_RST)
      | (hit_ist ? 32'({int_stat_r}) : `CRM_WORD_RST)
      | (hit_imsk ? 32'({int_mask_r}) : `CRM_WORD_RST)
      | (hit_fen ? 32'({flt_en_r}) : `CRM_WORD_RST)
      | (hit_ftgt ? 32'({flt_tgt_r}) : `CRM_WORD_RST);

   // capturing in setup keeps prdata steady through the access
   // cycle, even when a flag sets in that same cycle
   // read data and error captured in the setup phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_r <= `CRM_WORD_RST;
         err_r <= 1'b0;
      end else if (setup_w) begin
         prdata_r <= (pwrite || !hit_any_w) ? `CRM_WORD_RST : rd_w;
         err_r <= !hit_any_w;
      end
   end

   // plain configuration registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         msel_r <= `CRM_CFG_RST;
         flt_en_r <= '0;
         flt_tgt_r <= '0;
         int_mask_r <= '0;
      end else if (wr_w) begin
         // select fields for filters 8 to 11 in bits 7-0
         if (hit_msel) begin
            msel_r <= 16'(merge({16'h0000, msel_r}, pwdata, wm_w)) & 16'h00FF;
         end
         if (hit_fen) begin
            flt_en_r <= N_FLT'(merge(32'(flt_en_r), pwdata, wm_w));
         end
         if (hit_ftgt) begin
            flt_tgt_r <= (N_FLT*BUF_W)'(merge(32'(flt_tgt_r), pwdata, wm_w));
         end
         if (hit_imsk) begin
            int_mask_r <= `CRM_EV_W'(merge(32'(int_mask_r), pwdata, wm_w));
         end
      end
   end

   // masks are muxed per filter so each compare stays small
   // filter compare, one instance per filter
   logic [N_FLT-1:0] match_w;      // raw match per filter
   logic [15:0] sel_sid_w [N_FLT]; // chosen standard mask
   logic [15:0] sel_eid_w [N_FLT]; // chosen extended mask
   logic [`CRM_MSEL_W-1:0] msel_w [N_FLT];
   for (genvar f = 0; f < N_FLT; f++) begin : g_flt
      assign msel_w[f] = msel_r[`CRM_MSEL_W*f +: `CRM_MSEL_W];
      // reserved code falls back to mask 0
      assign sel_sid_w[f] =
         (msel_w[f] == crm_pkg::CRM_MSK1) ? mask_sid_r[1] :
         (msel_w[f] == crm_pkg::CRM_MSK2) ? mask_sid_r[2] : mask_sid_r[0];
      assign sel_eid_w[f] =
         (msel_w[f] == crm_pkg::CRM_MSK1) ? mask_eid_r[1] :
         (msel_w[f] == crm_pkg::CRM_MSK2) ? mask_eid_r[2] : mask_eid_r[0];
      crm_filter u_flt (
         .mask_sid(sel_sid_w[f]),
         .mask_eid(sel_eid_w[f]),
         .flt_sid(flt_sid_r[f]),
         .flt_eid(flt_eid_r[f]),
         .msg_ide(msg_ide),
         .msg_sid(msg_sid),
         .msg_eid(msg_eid),
         .match(match_w[f])
      );
   end

   // fixed priority keeps the choice stable when masks overlap;
   // software should still avoid overlapping filters
   // lowest enabled matching filter wins
   logic [N_FLT-1:0] hit_flt_w;
   logic [N_FLT-1:0] win_w;        // one-hot winner
   logic accept_w;                 // message is taken by some filter
   logic [BUF_W-1:0] tgt_w;        // buffer of the winner
   logic [1:0] win_idx_w;          // index of the winner
   assign hit_flt_w = match_w & flt_en_r;
   assign win_w = hit_flt_w & (~hit_flt_w + N_FLT'(1));
   assign accept_w = msg_valid && (|hit_flt_w);
   always_comb begin
      tgt_w = '0;
      win_idx_w = 2'h0;
      for (int i = 0; i < N_FLT; i++) begin
         if (win_w[i]) begin
            tgt_w = flt_tgt_r[BUF_W*i +: BUF_W];
            win_idx_w = 2'(i);
         end
      end
   end

   // set vectors from the accepted message
   logic [N_BUF-1:0] tgt_oh_w;     // one-hot target buffer
   logic tgt_full_w;               // target already holds a message
   logic [N_BUF-1:0] set_full_w, set_ovf_w;
   assign tgt_oh_w = N_BUF'(1) << tgt_w;
   assign tgt_full_w = full_r[tgt_w];
   assign set_full_w = (accept_w && !tgt_full_w) ? tgt_oh_w : '0;
   assign set_ovf_w = (accept_w && tgt_full_w) ? tgt_oh_w : '0;

   // lanes with strobe low are left alone, as for any other write
   // software clears: a zero written in an enabled lane clears that flag
   logic [15:0] clr16_w;           // clear pattern of the write
   logic [N_BUF-1:0] clr_full_w, clr_ovf_w;
   assign clr16_w = ~pwdata[15:0] & wm_w[15:0];
   assign clr_full_w = {(wr_w && hit_full_hi) ? clr16_w : 16'h0000,
                        (wr_w && hit_full_lo) ? clr16_w : 16'h0000};
   assign clr_ovf_w = {(wr_w && hit_ovf_hi) ? clr16_w : 16'h0000,
                       (wr_w && hit_ovf_lo) ? clr16_w : 16'h0000};

   // both flag vectors share one update form, so set beats clear
   // flag update
   logic [N_BUF-1:0] full_nxt, ovf_nxt;
   // set applied after clear so it wins
   assign full_nxt = (full_r & ~clr_full_w) | set_full_w;
   assign ovf_nxt = (ovf_r & ~clr_ovf_w) | set_ovf_w;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         full_r <= {`CRM_FLAG_RST, `CRM_FLAG_RST};
         ovf_r <= {`CRM_FLAG_RST, `CRM_FLAG_RST};
      end else begin
         full_r <= full_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // status only records events; the mask gates the line
   // interrupt events, write one to clear, event beats clear
   logic [`CRM_EV_W-1:0] ev_w, ist_clr_w, int_stat_nxt;
   assign ev_w[`CRM_EV_FULL] = |set_full_w;
   assign ev_w[`CRM_EV_OVF] = |set_ovf_w;
   assign ist_clr_w = (wr_w && hit_ist) ? (pwdata[`CRM_EV_W-1:0] & wm_w[`CRM_EV_W-1:0])
                                         : '0;
   assign int_stat_nxt = (int_stat_r & ~ist_clr_w) | ev_w;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= int_stat_nxt;
      end
   end
   // level interrupt from registered status
   assign irq = |(int_stat_r & int_mask_r);

   // buf and filter hold so a slow buffer writer can still read them
   // store notice toward the buffer writer, one cycle pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_store_valid <= 1'b0;
         rx_store_overflow <= 1'b0;
         rx_store_buf <= '0;
         rx_store_filter <= 4'h0;
      end else begin
         rx_store_valid <= accept_w;
         rx_store_overflow <= accept_w && tgt_full_w;
         if (accept_w) begin
            // held until the next accepted message
            rx_store_buf <= tgt_w;
            rx_store_filter <= 4'h8 + {2'h0, win_idx_w};
         end
      end
   end
endmodule

// File: hw/crm_regs.svh
// register offsets, field positions, reset values and write masks
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH

// apb byte offsets, one aligned word per register
`define CRM_OFF_MSEL     8'h00
`define CRM_OFF_MSID0    8'h04
`define CRM_OFF_MEID0    8'h10
`define CRM_OFF_FULL_LO  8'h1C
`define CRM_OFF_FULL_HI  8'h20
`define CRM_OFF_OVF_LO   8'h24
`define CRM_OFF_OVF_HI   8'h28
`define CRM_OFF_INT_STAT 8'h2C
`define CRM_OFF_INT_MASK 8'h30
`define CRM_OFF_FLT_EN   8'h34
`define CRM_OFF_FLT_TGT  8'h38
`define CRM_OFF_FSID0    8'h40
`define CRM_OFF_FEID0    8'h50

// identifier register layout, shared by mask and filter value registers
`define CRM_SID_MSB      15
`define CRM_SID_LSB      5
`define CRM_MODE_BIT     3
`define CRM_FLT_XEN_BIT  3
`define CRM_EIDH_MSB     1
`define CRM_SID_WMASK    16'hFFEB

// mask select field width per filter
`define CRM_MSEL_W       2

// interrupt event bit positions
`define CRM_EV_FULL      0
`define CRM_EV_OVF       1
`define CRM_EV_W         2

// reset values
`define CRM_FLAG_RST     16'h0000
`define CRM_CFG_RST      16'h0000
`define CRM_WORD_RST     32'h0000_0000

`endif

// File: hw/crm_pkg.sv
// types shared by the receive mask and buffer status block
package crm_pkg;
   // mask source select codes, 2'h3 is reserved
   typedef enum logic [1:0] {
      CRM_MSK0 = 2'h0,
      CRM_MSK1 = 2'h1,
      CRM_MSK2 = 2'h2,
      CRM_MRSV = 2'h3
   } crm_msel_e;
endpackage

// File: hw/crm_filter.sv
// one acceptance filter compare against a selected mask
`timescale 1ns/10ps
`include "crm_regs.svh"
module crm_filter (
   input wire logic [15:0] mask_sid,
   input wire logic [15:0] mask_eid,
   input wire logic [15:0] flt_sid,
   input wire logic [15:0] flt_eid,
   input wire logic msg_ide,
   input wire logic [10:0] msg_sid,
   input wire logic [17:0] msg_eid,
   output logic match
);
   // compare terms
   logic [10:0] sid_diff; // differing standard bits that take part
   logic [17:0] eid_diff; // differing extended bits that take part
   logic sid_ok;
   logic eid_ok;
   logic id_type_match_mode; // mode bit from the mask
   logic filter_extended_enable; // frame type the filter expects
   logic type_ok;
   logic id_ok;

   assign sid_diff = (flt_sid[`CRM_SID_MSB:`CRM_SID_LSB] ^ msg_sid)
                     & mask_sid[`CRM_SID_MSB:`CRM_SID_LSB];
   assign eid_diff = ({flt_sid[`CRM_EIDH_MSB:0], flt_eid} ^ msg_eid)
                     & {mask_sid[`CRM_EIDH_MSB:0], mask_eid};
   assign sid_ok = (sid_diff == 11'h0);
   assign eid_ok = (eid_diff == 18'h0_0000);
   assign id_type_match_mode = mask_sid[`CRM_MODE_BIT];
   assign filter_extended_enable = flt_sid[`CRM_FLT_XEN_BIT];
   // frame type check only in strict mode
   assign type_ok = !id_type_match_mode || (msg_ide == filter_extended_enable);
   // standard frames carry no extended bits to compare
   assign id_ok = msg_ide ? (sid_ok && eid_ok) : sid_ok;
   assign match = type_ok && id_ok;
endmodule

// File: verification/crm_top_checker.sv
// assertion checker for the receive mask and buffer status block
`timescale 1ns/10ps
`include "crm_regs.svh"
module crm_top_checker #(
   parameter int BUF_W = 5
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic msg_valid,
   input wire logic rx_store_valid,
   input wire logic [BUF_W-1:0] rx_store_buf,
   input wire logic [3:0] rx_store_filter,
   input wire logic rx_store_overflow,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // read access phase, prdata must be final here
   wire logic rd_acc = psel && penable && !pwrite;
   a_store_cause: assert property (rx_store_valid |-> $past(msg_valid))
      else $error("store pulse without a message");
   a_ovf_in_store: assert property (rx_store_overflow |-> rx_store_valid)
      else $error("overflow pulse outside a store");
   a_filter_range: assert property (rx_store_valid |-> rx_store_filter inside {[8:11]})
      else $error("winning filter outside 8 to 11");
   a_reset_quiet: assert property ($fell(rst) |-> !irq && !rx_store_valid)
      else $error("activity right after reset");
   a_msid_gaps: assert property (rd_acc && paddr inside {8'h04, 8'h08, 8'h0C} |->
      prdata[4] == 1'b0 && prdata[2] == 1'b0) else $error("mask gap bits read one");
   a_flag_width: assert property (rd_acc && paddr inside {8'h1C, 8'h20, 8'h24, 8'h28} |->
      prdata[31:16] == 16'h0000) else $error("flag register upper half not zero");
   a_msel_width: assert property (rd_acc && paddr == 8'h00 |->
      prdata[31:8] == 24'h00_0000) else $error("select register upper bits not zero");
   a_target_held: assert property (!rx_store_valid |->
      $stable(rx_store_buf) && $stable(rx_store_filter)) else $error("target moved idle");
endmodule

// File: verification/crm_can_node.sv
// behavioural far node handing received messages to the block
`timescale 1ns/10ps
module crm_can_node (
   input wire logic mclk,
   output logic msg_valid,
   output logic msg_ide,
   output logic [10:0] msg_sid,
   output logic [17:0] msg_eid
);
   // quiet bus at time zero
   initial begin
      msg_valid = 1'b0;
      msg_ide = 1'b0;
      msg_sid = 11'h000;
      msg_eid = 18'h0_0000;
   end
   // one-cycle message after g idle cycles, so slow senders are covered
   task automatic send(input logic i, input logic [10:0] s, input logic [17:0] e, input int g);
      repeat (g) @(posedge mclk);
      @(posedge mclk);
      msg_valid <= 1'b1;
      msg_ide <= i;
      msg_sid <= s;
      msg_eid <= e;
      @(posedge mclk);
      // inverted leftovers catch a block that reads stale ids
      msg_valid <= 1'b0;
      msg_ide <= ~i;
      msg_sid <= ~s;
      msg_eid <= ~e;
   endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the receive mask and buffer status block
`timescale 1ns/10ps
`include "crm_regs.svh"
module tb_top;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, err_q, irq;
   logic msg_valid, msg_ide, rx_store_valid, rx_store_overflow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_q, full_m, ovf_m;
   logic [3:0] pstrb, rx_store_filter;
   logic [10:0] msg_sid;
   logic [17:0] msg_eid;
   logic [4:0] rx_store_buf;
   logic [1:0] stat_m; // expected interrupt status
   int bad_count, total_checks;
   crm_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .msg_valid(msg_valid), .msg_ide(msg_ide), .msg_sid(msg_sid),
      .msg_eid(msg_eid), .rx_store_valid(rx_store_valid), .rx_store_buf(rx_store_buf),
      .rx_store_filter(rx_store_filter), .rx_store_overflow(rx_store_overflow), .irq(irq));
   crm_can_node u_node (.mclk(mclk), .msg_valid(msg_valid), .msg_ide(msg_ide),
      .msg_sid(msg_sid), .msg_eid(msg_eid));
   // free running 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // a slave that never answers ends the run
      if (pready !== 1'b1) begin
         bad_count++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd_q, e);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge mclk);
      chk("irq", 32'(irq), 32'(e));
   endtask
   task automatic rd_flags;
      rd(`CRM_OFF_FULL_LO, {16'h0000, full_m[15:0]}, "full_lo");
      rd(`CRM_OFF_FULL_HI, {16'h0000, full_m[31:16]}, "full_hi");
      rd(`CRM_OFF_OVF_LO, {16'h0000, ovf_m[15:0]}, "ovf_lo");
      rd(`CRM_OFF_OVF_HI, {16'h0000, ovf_m[31:16]}, "ovf_hi");
   endtask
   // send one message; f is the expected filter, zero when none may match
   task automatic msg(input logic i, input logic [10:0] s, input logic [17:0] e,
      input logic [3:0] f, input int g);
      int n;
      logic [4:0] b;
      u_node.send(i, s, e, g);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (rx_store_valid !== 1'b1 && n < 3);
      chk("store", 32'(rx_store_valid), 32'(f != 4'h0));
      if (f != 4'h0) begin
         // targets set up as 8->0, 9->17, 10->15, 11->31
         b = (f == 4'h8) ? 5'h00 : (f == 4'h9) ? 5'h11 : (f == 4'hA) ? 5'h0F : 5'h1F;
         chk("filter", 32'(rx_store_filter), 32'(f));
         chk("buf", 32'(rx_store_buf), 32'(b));
         chk("ovf", 32'(rx_store_overflow), 32'(full_m[b]));
         // event kind follows the full state before this store
         stat_m[full_m[b] ? 1 : 0] = 1'b1;
         if (full_m[b]) ovf_m[b] = 1'b1;
         else full_m[b] = 1'b1;
      end
   endtask
   task automatic t_regs;
      wr(`CRM_OFF_MSID0, 32'hFFFF_FFFF);
      rd(`CRM_OFF_MSID0, 32'h0000_FFEB, "msid");
      wr(`CRM_OFF_MEID0, 32'hFFFF_FFFF);
      rd(`CRM_OFF_MEID0, 32'h0000_FFFF, "meid");
      // only the strobed low lane may change
      pstrb <= 4'h1;
      wr(`CRM_OFF_MEID0, 32'h0000_0000);
      pstrb <= 4'hF;
      rd(`CRM_OFF_MEID0, 32'h0000_FF00, "strobe");
      wr(`CRM_OFF_MSEL, 32'hFFFF_FFFF);
      rd(`CRM_OFF_MSEL, 32'h0000_00FF, "msel");
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk("unmapped", {rd_q[31:1], ~err_q}, 32'h0000_0000);
   endtask
   // masks: 0 exact, 1 top three id bits, 2 anything; selects 8:0 9:1 10:2 11:1
   task automatic t_setup;
      wr(`CRM_OFF_MSEL, 32'h0000_0064);
      wr(`CRM_OFF_MSID0, 32'h0000_FFE0);
      wr(`CRM_OFF_MEID0, 32'h0000_0000);
      wr(8'h08, 32'h0000_E000);
      wr(8'h0C, 32'h0000_0000);
      wr(`CRM_OFF_FSID0, 32'h0000_2000);
      wr(8'h44, 32'h0000_4000);
      wr(8'h48, 32'h0000_6000);
      wr(8'h4C, 32'h0000_8000);
      wr(`CRM_OFF_FLT_TGT, 32'h000F_BE20);
      wr(`CRM_OFF_FLT_EN, 32'h0000_000F);
   endtask
   task automatic t_match;
      msg(1'b0, 11'h100, 18'h0_0000, 4'h8, 0);
      msg(1'b0, 11'h2FF, 18'h0_0000, 4'h9, 0);
      msg(1'b0, 11'h123, 18'h0_0000, 4'hA, 0);
      msg(1'b1, 11'h100, 18'h3_0001, 4'h8, 0);
      wr(`CRM_OFF_MSID0, 32'h0000_FFE3);
      wr(`CRM_OFF_MEID0, 32'h0000_FFFF);
      msg(1'b1, 11'h100, 18'h3_0000, 4'hA, 0);
      msg(1'b1, 11'h100, 18'h0_0001, 4'hA, 0);
      msg(1'b1, 11'h100, 18'h0_0000, 4'h8, 0);
      wr(`CRM_OFF_MSID0, 32'h0000_FFEB);
      msg(1'b1, 11'h100, 18'h0_0000, 4'hA, 0);
      msg(1'b0, 11'h100, 18'h0_0000, 4'h8, 0);
      wr(`CRM_OFF_FLT_EN, 32'h0000_000B);
      msg(1'b0, 11'h4AB, 18'h0_0000, 4'hB, 0);
      msg(1'b0, 11'h123, 18'h0_0000, 4'h0, 0);
      msg(1'b0, 11'h2FF, 18'h0_0000, 4'h9, 3);
      // reserved code on filter 11 falls back to exact mask 0
      wr(`CRM_OFF_MSEL, 32'h0000_00E4);
      msg(1'b0, 11'h400, 18'h0_0000, 4'hB, 0);
      msg(1'b0, 11'h4AB, 18'h0_0000, 4'h0, 0);
   endtask
   task automatic t_flags;
      rd_flags();
      wr(`CRM_OFF_FULL_LO, 32'h0000_7FFF);
      wr(`CRM_OFF_FULL_HI, 32'h0000_FFFF);
      full_m[15] = 1'b0;
      rd_flags();
      wr(`CRM_OFF_FULL_LO, 32'h0000_FFFE);
      full_m[0] = 1'b0;
      // clear of buffer 0 lands on the same edge as a new store there
      fork
         wr(`CRM_OFF_FULL_LO, 32'h0000_FFFE);
         begin
            @(posedge mclk);
            msg(1'b0, 11'h100, 18'h0_0000, 4'h8, 0);
         end
      join
      rd(`CRM_OFF_FULL_LO, {16'h0000, full_m[15:0]}, "set_wins");
      wr(`CRM_OFF_FULL_LO, 32'h0000_0000);
      wr(`CRM_OFF_FULL_HI, 32'h0000_0000);
      wr(`CRM_OFF_OVF_LO, 32'h0000_0000);
      wr(`CRM_OFF_OVF_HI, 32'h0000_0000);
      full_m = 32'h0000_0000;
      ovf_m = 32'h0000_0000;
      rd_flags();
   endtask
   task automatic t_irq;
      rd(`CRM_OFF_INT_STAT, {30'h0, stat_m}, "int_stat");
      chk_irq(1'b0);
      wr(`CRM_OFF_INT_MASK, 32'h0000_0001);
      chk_irq(1'b1);
      wr(`CRM_OFF_INT_STAT, 32'h0000_0001);
      chk_irq(1'b0);
      wr(`CRM_OFF_INT_MASK, 32'h0000_0002);
      chk_irq(1'b1);
      wr(`CRM_OFF_INT_STAT, 32'h0000_0002);
      chk_irq(1'b0);
      rd(`CRM_OFF_INT_STAT, 32'h0000_0000, "int_clr");
   endtask
   // main sequence
   initial begin
      bad_count = 0;
      total_checks = 0;
      full_m = 32'h0000_0000;
      ovf_m = 32'h0000_0000;
      stat_m = 2'h0;
      {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 8'h00, 32'h0000_0000, 4'hF};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd_flags();
      chk_irq(1'b0);
      t_regs();
      t_setup();
      t_match();
      t_flags();
      t_irq();
      finish_test();
   end
endmodule
bind crm_top crm_top_checker #(.BUF_W(BUF_W)) u_chk (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .msg_valid(msg_valid),
   .rx_store_valid(rx_store_valid), .rx_store_buf(rx_store_buf),
   .rx_store_filter(rx_store_filter), .rx_store_overflow(rx_store_overflow), .irq(irq));
